/* design/rtcc_map.vh */
// Register map, field positions, limits and integrity flag reset value of the time and date counters
// ==========================================================================
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH
// ==========================================================================
// Register offsets
`define RTCC_ADDR_SECONDS 8'h02
`define RTCC_ADDR_MINUTES 8'h03
`define RTCC_ADDR_HOURS   8'h04
`define RTCC_ADDR_DATE    8'h05
`define RTCC_ADDR_WEEKDAY 8'h06
`define RTCC_ADDR_MONTH   8'h07
`define RTCC_ADDR_YEAR    8'h08
// ==========================================================================
// Field positions and limits
`define RTCC_FLAG_BIT     7
`define RTCC_CENTURY_BIT  7
`define RTCC_FLAG_RESET   1'b1
`define RTCC_SEC_MAX      7'h59
`define RTCC_MIN_MAX      7'h59
`define RTCC_HOUR_MAX     6'h23
`define RTCC_DATE_MIN     6'h01
`define RTCC_MONTH_MIN    5'h01
`define RTCC_MONTH_MAX    5'h12
`define RTCC_YEAR_MAX     8'h99
`define RTCC_WDAY_MAX     3'h6
`endif

/* design/rtcc_bcd_step.v */
// Two-digit packed BCD incrementer with wrap
`default_nettype none
module rtcc_bcd_step (
  // Value in and limits
  input  wire [7:0] value,
  input  wire [7:0] max_value,
  input  wire [7:0] min_value,
  // Result
  output wire [7:0] next_value,
  output wire       wrap
);
  // Low digit rolls at nine into the high digit
  wire [7:0] inc_value;
  assign inc_value  = (value[3:0] == 4'h9) ? {value[7:4] + 4'h1, 4'h0} : {value[7:4], value[3:0] + 4'h1};
  // Wrap at or above limit so an illegal value recovers
  assign wrap       = (value >= max_value);
  assign next_value = wrap ? min_value : inc_value;
endmodule
`default_nettype wire

/* design/rtcc_counters.v */
// Time of day and calendar counters with register port
`include "rtcc_map.vh"
`default_nettype none
module rtcc_counters (
  // Clock and reset
  input  wire       clock,
  input  wire       nrst,
  input  wire       clk_en,
  // One-second tick from oscillator chain and oscillator stop event
  input  wire       sec_tick,
  input  wire       osc_fail,
  // Register port from serial interface
  input  wire       reg_wr,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata
);
  // ========================================================================
  // Counter state
  reg        clock_integrity_lost_flag;
  reg  [6:0] sec;
  reg  [6:0] min;
  reg  [5:0] hour;
  reg  [5:0] date;
  reg  [2:0] wday;
  reg  [4:0] month;
  reg        century_toggle_bit;
  reg  [7:0] year;

  // ========================================================================
  // Month length with leap years, valid 2000 to 2099
  wire       leap;
  reg  [7:0] month_end;
  // Every fourth year; 2000 is leap so no century exception in range
  assign leap = (year[4] == 1'b0) ? (year[1:0] == 2'b00 && (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                year[3:0] == 4'h8)) : (year[3:0] == 4'h2 || year[3:0] == 4'h6);
  always @* begin
    case (month)
      5'h02:   month_end = leap ? 8'h29 : 8'h28;
      5'h04:   month_end = 8'h30;
      5'h06:   month_end = 8'h30;
      5'h09:   month_end = 8'h30;
      5'h11:   month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  end

  // ========================================================================
  // Incrementers, one per field byte: sec, min, hour, date, month, year from the low byte up
  wire [47:0] step_value;
  wire [47:0] step_max;
  wire [47:0] step_min;
  wire [47:0] step_next;
  wire [5:0]  step_wrap;
  assign step_value = {year, 3'b000, month, 2'b00, date, 2'b00, hour, 1'b0, min, 1'b0, sec};
  assign step_max   = {`RTCC_YEAR_MAX, 3'b000, `RTCC_MONTH_MAX, month_end, 2'b00, `RTCC_HOUR_MAX,
                       1'b0, `RTCC_MIN_MAX, 1'b0, `RTCC_SEC_MAX};
  assign step_min   = {8'h00, 3'b000, `RTCC_MONTH_MIN, 2'b00, `RTCC_DATE_MIN, 8'h00, 8'h00, 8'h00};
  genvar fi;
  generate
    for (fi = 0; fi < 6; fi = fi + 1) begin : g_step
      rtcc_bcd_step u_step (
        .value      (step_value[8*fi+7:8*fi]),
        .max_value  (step_max[8*fi+7:8*fi]),
        .min_value  (step_min[8*fi+7:8*fi]),
        .next_value (step_next[8*fi+7:8*fi]),
        .wrap       (step_wrap[fi])
      );
    end
  endgenerate

  // Next values of each field; padding bits of each byte dropped on purpose
  wire [6:0] next_sec;
  wire [6:0] next_min;
  wire [5:0] next_hour;
  wire [5:0] next_date;
  wire [4:0] next_month;
  wire [7:0] next_year;
  wire [2:0] next_wday;
  assign next_sec   = step_next[6:0];
  assign next_min   = step_next[14:8];
  assign next_hour  = step_next[21:16];
  assign next_date  = step_next[29:24];
  assign next_month = step_next[36:32];
  assign next_year  = step_next[47:40];
  assign next_wday  = (wday >= `RTCC_WDAY_MAX) ? 3'h0 : wday + 3'h1;

  // Carry chain; the century bit flips only when the year itself wraps
  wire c_min;
  wire c_hour;
  wire c_day;
  wire c_month;
  wire c_year;
  wire c_century;
  assign c_min     = sec_tick & step_wrap[0];
  assign c_hour    = c_min & step_wrap[1];
  assign c_day     = c_hour & step_wrap[2];
  assign c_month   = c_day & step_wrap[3];
  assign c_year    = c_month & step_wrap[4];
  assign c_century = c_year & step_wrap[5];

  // ========================================================================
  // Oscillator stop event comes from the oscillator side: two flops before use
  // A stop event shorter than one clock period can be missed
  reg osc_fail_meta;
  reg osc_fail_sync;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_fail_meta <= 1'b0;
      osc_fail_sync <= 1'b0;
    end else if (clk_en) begin
      osc_fail_meta <= osc_fail;
      osc_fail_sync <= osc_fail_meta;
    end
  end

  // Integrity flag: only counter state with a reset value; oscillator stop wins over write
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clock_integrity_lost_flag <= `RTCC_FLAG_RESET;
    end else if (clk_en) begin
      if (osc_fail_sync) begin
        clock_integrity_lost_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `RTCC_ADDR_SECONDS) begin
        clock_integrity_lost_flag <= reg_wdata[`RTCC_FLAG_BIT];
      end
    end
  end

  // ========================================================================
  // Counters carry no reset; a host write overrides the tick for that field
  // Seconds
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_SECONDS) begin
        sec <= reg_wdata[6:0];
      end else if (sec_tick) begin
        sec <= next_sec;
      end
    end
  end

  // Minutes
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_MINUTES) begin
        min <= reg_wdata[6:0];
      end else if (c_min) begin
        min <= next_min;
      end
    end
  end

  // Hours
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_HOURS) begin
        hour <= reg_wdata[5:0];
      end else if (c_hour) begin
        hour <= next_hour;
      end
    end
  end

  // Day of month
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_DATE) begin
        date <= reg_wdata[5:0];
      end else if (c_day) begin
        date <= next_date;
      end
    end
  end

  // Weekday advances with the day carry
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_WEEKDAY) begin
        wday <= reg_wdata[2:0];
      end else if (c_day) begin
        wday <= next_wday;
      end
    end
  end

  // Month and century bit share one register
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_MONTH) begin
        month              <= reg_wdata[4:0];
        century_toggle_bit <= reg_wdata[`RTCC_CENTURY_BIT];
      end else begin
        if (c_month) begin
          month <= next_month;
        end
        if (c_century) begin
          century_toggle_bit <= ~century_toggle_bit;
        end
      end
    end
  end

  // Year
  always @(posedge clock) begin
    if (clk_en) begin
      if (reg_wr && reg_addr == `RTCC_ADDR_YEAR) begin
        year <= reg_wdata;
      end else if (c_year) begin
        year <= next_year;
      end
    end
  end

  // ========================================================================
  // Read data, unused bits read as zero
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      case (reg_addr)
        `RTCC_ADDR_SECONDS: reg_rdata <= {clock_integrity_lost_flag, sec};
        `RTCC_ADDR_MINUTES: reg_rdata <= {1'b0, min};
        `RTCC_ADDR_HOURS:   reg_rdata <= {2'b00, hour};
        `RTCC_ADDR_DATE:    reg_rdata <= {2'b00, date};
        `RTCC_ADDR_WEEKDAY: reg_rdata <= {5'h00, wday};
        `RTCC_ADDR_MONTH:   reg_rdata <= {century_toggle_bit, 2'b00, month};
        `RTCC_ADDR_YEAR:    reg_rdata <= year;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

/* test/rtcc_host_model.sv */
// Host master model for the counter register port
`default_nettype none
module rtcc_host_model (
  // Clock
  input  wire logic       clock,
  // Register port and events
  output var  logic       reg_wr,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       sec_tick,
  output var  logic       osc_fail,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus
  initial begin
    {reg_wr, sec_tick, osc_fail} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
  end
  // Write strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Address taken at the next edge; read data stands after it and is taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    @(negedge clock);
    d = reg_rdata;
  endtask
  // One-cycle tick or oscillator stop pulse
  task automatic pulse(input logic fail);
    @(posedge clock);
    {sec_tick, osc_fail} <= {!fail, fail};
    @(posedge clock);
    {sec_tick, osc_fail} <= 2'h0;
  endtask
endmodule
`default_nettype wire

/* test/rtcc_counters_chk.sv */
// Concurrent checks on the counter register port
`default_nettype none
module rtcc_counters_chk (
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       clk_en,
  // Events and register port
  input wire logic       sec_tick,
  input wire logic       osc_fail,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Written field reads back unchanged
  property wb(a, m);
    (clk_en && reg_wr && reg_addr == a && !sec_tick) ##1 (clk_en && reg_addr == a && !reg_wr && !sec_tick)
      |=> (reg_rdata & m) == ($past(reg_wdata, 2) & m);
  endproperty
  chk_sec_write: assert property (wb(8'h02, 8'h7f)) else $error("seconds readback wrong");
  chk_min_write: assert property (wb(8'h03, 8'h7f)) else $error("minutes readback wrong");
  chk_hour_write: assert property (wb(8'h04, 8'h3f)) else $error("hours readback wrong");
  chk_date_write: assert property (wb(8'h05, 8'h3f)) else $error("date readback wrong");
  chk_wday_write: assert property (wb(8'h06, 8'h07)) else $error("weekday readback wrong");
  // Stop event passes two synchroniser flops before the flag rises
  chk_flag_set: assert property ((osc_fail && clk_en) ##1 clk_en ##1 clk_en ##1 (clk_en && reg_addr == 8'h02)
    |=> reg_rdata[7]) else $error("integrity flag not set");
  chk_unmapped_zero: assert property ((clk_en && (reg_addr < 8'h02 || reg_addr > 8'h08)) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_sec_wrap: assert property ((sec_tick && clk_en && $past(clk_en) && !reg_wr && !$past(reg_wr)
    && !$past(sec_tick) && $stable(reg_addr) && reg_addr == 8'h02 && reg_rdata[6:0] == 7'h59)
    ##1 (clk_en && reg_addr == 8'h02 && !reg_wr) |=> reg_rdata[6:0] == 7'h00) else $error("seconds did not wrap");
  // Main scenarios
  cover property (sec_tick);
  cover property (!clk_en && sec_tick);
  cover property (osc_fail);
  cover property (reg_wr && reg_addr > 8'h08);
endmodule
bind rtcc_counters rtcc_counters_chk u_chk (.clock(clock), .nrst(nrst), .clk_en(clk_en), .sec_tick(sec_tick),
  .osc_fail(osc_fail), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
`default_nettype wire

/* test/rtc_time_date_counters_tb_top.sv */
// Self-checking bench for the time and date counters
`default_nettype none
module rtc_time_date_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, nrst, clk_en, reg_wr, sec_tick, osc_fail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         n_fail = 0;
  int         total_checks = 0;
  logic [7:0] ua [5] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h0a};
  logic [7:0] uw [5] = '{8'hc7, 8'hd5, 8'he9, 8'hfb, 8'h55};
  logic [7:0] ue [5] = '{8'h47, 8'h15, 8'h29, 8'h03, 8'h00};
  rtcc_counters DUT (.clock(clock), .nrst(nrst), .clk_en(clk_en), .sec_tick(sec_tick), .osc_fail(osc_fail),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rtcc_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .sec_tick(sec_tick), .osc_fail(osc_fail), .reg_rdata(reg_rdata));
  // ========================================
  // Clock, verdict and compare
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    host.rd(a, d);
    total_checks++;
    if ((d & m) !== e) begin
      n_fail++;
      $display("MISMATCH reg %h expected %h seen %h", a, e, d & m);
    end
  endtask
  // Load last second of a day, tick once, check the carries
  task automatic roll(input logic [7:0] d, m, y, ed, em, ey);
    host.wr(8'h02, 8'h59);
    host.wr(8'h03, 8'h59);
    host.wr(8'h04, 8'h23);
    host.wr(8'h05, d);
    host.wr(8'h06, 8'h06);
    host.wr(8'h07, m);
    host.wr(8'h08, y);
    rchk(8'h02, 8'h59, 8'hff);
    host.pulse(1'b0);
    rchk(8'h02, 8'h00, 8'h7f);
    rchk(8'h03, 8'h00, 8'h7f);
    rchk(8'h04, 8'h00, 8'h3f);
    rchk(8'h05, ed, 8'h3f);
    rchk(8'h06, 8'h00, 8'h07);
    rchk(8'h07, em, 8'hff);
    rchk(8'h08, ey, 8'hff);
  endtask
  // ========================================
  // Test sequence
  initial begin
    clk_en = 1'b1;
    nrst = 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rchk(8'h02, 8'h80, 8'h80);
    host.wr(8'h02, 8'h00);
    rchk(8'h02, 8'h00, 8'hff);
    host.pulse(1'b1);
    // Let the stop event pass the two-flop synchroniser
    repeat (2) @(posedge clock);
    rchk(8'h02, 8'h80, 8'h80);
    for (int i = 0; i < 5; i++) begin
      host.wr(ua[i], uw[i]);
      rchk(ua[i], ue[i], 8'hff);
    end
    roll(8'h31, 8'h12, 8'h99, 8'h01, 8'h81, 8'h00);
    roll(8'h28, 8'h02, 8'h24, 8'h29, 8'h02, 8'h24);
    roll(8'h29, 8'h02, 8'h24, 8'h01, 8'h03, 8'h24);
    roll(8'h28, 8'h02, 8'h23, 8'h01, 8'h03, 8'h23);
    roll(8'h28, 8'h02, 8'h00, 8'h29, 8'h02, 8'h00);
    roll(8'h30, 8'h04, 8'h23, 8'h01, 8'h05, 8'h23);
    roll(8'h31, 8'h12, 8'h24, 8'h01, 8'h01, 8'h25);
    // Clock enable low: tick and write are both ignored
    @(posedge clock);
    clk_en <= 1'b0;
    host.pulse(1'b0);
    host.wr(8'h03, 8'h11);
    clk_en <= 1'b1;
    rchk(8'h03, 8'h00, 8'h7f);
    host.pulse(1'b0);
    rchk(8'h02, 8'h01, 8'h7f);
    // Reset in mid-run sets the integrity flag again
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rchk(8'h02, 8'h80, 8'h80);
    tally_and_finish();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
